// >>> verilog/asx_top.sv
// asynchronous serial port: registers, receiver, pin control
// assumes an external baud generator feeding a 16x tick on clk_sys
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module asx_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire asx_pkg::asx_bus_req_type busReq,
  output logic [7:0] rdData,
  input wire logic tick16,
  input wire logic rxLine,
  output logic txLineOut,
  output logic txLineOe,
  output logic irq,
  output logic [15:0] baudDivisor,
  output logic highRateSel,
  output logic wideDivisorSel
);
  logic nineTx_reg;
  logic txOn_reg;
  logic syncMode_reg;
  logic ninthData_reg;
  logic portOn_reg;
  logic nineRx_reg;
  logic contRx_reg;
  logic txInvert_reg;
  logic globalIrq_reg;
  logic periphIrq_reg;
  logic rxIrqAllow_reg;
  logic txIrqAllow_reg;
  logic overrun_reg;
  logic rxSync1_reg;
  logic rxSync2_reg;
  logic rxPrev_reg;
  logic [3:0] rxCnt_reg;
  logic [1:0] votes_reg;
  logic [3:0] rxBits_reg;
  logic [8:0] rxShift_reg;
  asx_pkg::asx_rx_state_type rxState_reg;
  logic wrTxCtrl;
  logic wrTxBuf;
  logic rdRxData;
  logic txSerial;
  logic txHoldEmpty;
  logic txShiftEmpty;
  logic txFlag;
  logic rxFlag;
  logic rxActive;
  logic vote;
  logic decideNow;
  logic fifoPush;
  logic fifoEmpty;
  logic fifoFull;
  logic [3:0] dataBits;
  asx_pkg::asx_rx_char_type rxChar;
  asx_pkg::asx_rx_char_type fifoHead;

  // ****************************************
  // bus decode
  // ****************************************
  assign wrTxCtrl = busReq.wrStrobe && busReq.addr == asx_pkg::ADDR_TX_CTRL;
  assign wrTxBuf = busReq.wrStrobe && busReq.addr == asx_pkg::ADDR_TX_BUF;
  assign rdRxData = busReq.rdStrobe && busReq.addr == asx_pkg::ADDR_RX_DATA;
  assign txFlag = portOn_reg && txOn_reg && txHoldEmpty;
  assign rxFlag = !fifoEmpty;
  // sync mode is not built, so it only gates both directions off
  assign rxActive = contRx_reg && !syncMode_reg && portOn_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nineTx_reg <= 1'b0;
      txOn_reg <= 1'b0;
      syncMode_reg <= 1'b0;
      highRateSel <= 1'b0;
      ninthData_reg <= 1'b0;
    end else if (wrTxCtrl) begin
      nineTx_reg <= busReq.wrData[asx_pkg::TX_NINE_BIT];
      txOn_reg <= busReq.wrData[asx_pkg::TX_ON_BIT];
      syncMode_reg <= busReq.wrData[asx_pkg::TX_SYNC_BIT];
      highRateSel <= busReq.wrData[asx_pkg::TX_HIGH_RATE_BIT];
      ninthData_reg <= busReq.wrData[asx_pkg::TX_NINTH_DATA_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      portOn_reg <= 1'b0;
      nineRx_reg <= 1'b0;
      contRx_reg <= 1'b0;
    end else if (busReq.wrStrobe && busReq.addr == asx_pkg::ADDR_RX_CTRL) begin
      portOn_reg <= busReq.wrData[asx_pkg::RX_PORT_ON_BIT];
      nineRx_reg <= busReq.wrData[asx_pkg::RX_NINE_BIT];
      contRx_reg <= busReq.wrData[asx_pkg::RX_CONT_ON_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txInvert_reg <= 1'b0;
      wideDivisorSel <= 1'b0;
      baudDivisor <= {asx_pkg::RESET_BYTE, asx_pkg::RESET_BYTE};
    end else if (busReq.wrStrobe) begin
      unique case (busReq.addr)
        asx_pkg::ADDR_BAUD_POL: begin
          txInvert_reg <= busReq.wrData[asx_pkg::BP_TX_INVERT_BIT];
          wideDivisorSel <= busReq.wrData[asx_pkg::BP_WIDE_DIV_BIT];
        end
        asx_pkg::ADDR_DIV_HIGH: baudDivisor[15:8] <= busReq.wrData;
        asx_pkg::ADDR_DIV_LOW: baudDivisor[7:0] <= busReq.wrData;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {globalIrq_reg, periphIrq_reg, rxIrqAllow_reg, txIrqAllow_reg} <= 4'h0;
    end else if (busReq.wrStrobe && busReq.addr == asx_pkg::ADDR_IRQ_CTRL) begin
      globalIrq_reg <= busReq.wrData[asx_pkg::IRQ_GLOBAL_BIT];
      periphIrq_reg <= busReq.wrData[asx_pkg::IRQ_PERIPH_BIT];
      rxIrqAllow_reg <= busReq.wrData[asx_pkg::IRQ_RX_ALLOW_BIT];
      txIrqAllow_reg <= busReq.wrData[asx_pkg::IRQ_TX_ALLOW_BIT];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // unmapped or write-only addresses read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData <= asx_pkg::RESET_BYTE;
    end else if (busReq.rdStrobe) begin
      rdData <= asx_pkg::RESET_BYTE;
      unique case (busReq.addr)
        asx_pkg::ADDR_TX_CTRL: begin
          rdData[asx_pkg::TX_NINE_BIT] <= nineTx_reg;
          rdData[asx_pkg::TX_ON_BIT] <= txOn_reg;
          rdData[asx_pkg::TX_SYNC_BIT] <= syncMode_reg;
          rdData[asx_pkg::TX_HIGH_RATE_BIT] <= highRateSel;
          rdData[asx_pkg::TX_SHIFT_EMPTY_BIT] <= txShiftEmpty;
          rdData[asx_pkg::TX_NINTH_DATA_BIT] <= ninthData_reg;
        end
        asx_pkg::ADDR_RX_CTRL: begin
          rdData[asx_pkg::RX_PORT_ON_BIT] <= portOn_reg;
          rdData[asx_pkg::RX_NINE_BIT] <= nineRx_reg;
          rdData[asx_pkg::RX_CONT_ON_BIT] <= contRx_reg;
          rdData[asx_pkg::RX_FRAME_ERR_BIT] <= !fifoEmpty && fifoHead.frameErr;
          rdData[asx_pkg::RX_OVERRUN_BIT] <= overrun_reg;
          rdData[asx_pkg::RX_NINTH_DATA_BIT] <= !fifoEmpty && fifoHead.data[8];
        end
        asx_pkg::ADDR_RX_DATA: rdData <= fifoEmpty ? asx_pkg::RESET_BYTE : fifoHead.data[7:0];
        asx_pkg::ADDR_BAUD_POL: begin
          rdData[asx_pkg::BP_TX_INVERT_BIT] <= txInvert_reg;
          rdData[asx_pkg::BP_WIDE_DIV_BIT] <= wideDivisorSel;
        end
        asx_pkg::ADDR_DIV_HIGH: rdData <= baudDivisor[15:8];
        asx_pkg::ADDR_DIV_LOW: rdData <= baudDivisor[7:0];
        asx_pkg::ADDR_IRQ_CTRL: begin
          rdData[asx_pkg::IRQ_GLOBAL_BIT] <= globalIrq_reg;
          rdData[asx_pkg::IRQ_PERIPH_BIT] <= periphIrq_reg;
          rdData[asx_pkg::IRQ_RX_ALLOW_BIT] <= rxIrqAllow_reg;
          rdData[asx_pkg::IRQ_TX_ALLOW_BIT] <= txIrqAllow_reg;
          rdData[asx_pkg::IRQ_RX_FLAG_BIT] <= rxFlag;
          rdData[asx_pkg::IRQ_TX_FLAG_BIT] <= txFlag;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // transmitter and pin
  // ****************************************
  asx_tx u_tx (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(txOn_reg && portOn_reg && !syncMode_reg),
    .tick16(tick16),
    .nineBits(nineTx_reg),
    .load(wrTxBuf && txOn_reg && portOn_reg),
    .loadData({ninthData_reg, busReq.wrData}),
    .serialOut(txSerial),
    .holdEmpty(txHoldEmpty),
    .shiftEmpty(txShiftEmpty)
  );

  // port output latch is not modelled, so the pin floats when the port is off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txLineOe <= 1'b0;
      txLineOut <= 1'b0;
    end else begin
      txLineOe <= portOn_reg;
      txLineOut <= portOn_reg && (txSerial ^ txInvert_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= globalIrq_reg && periphIrq_reg &&
             ((txIrqAllow_reg && txFlag) || (rxIrqAllow_reg && rxFlag));
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxSync1_reg <= 1'b1;
      rxSync2_reg <= 1'b1;
      rxPrev_reg <= 1'b1;
    end else begin
      rxSync1_reg <= rxLine;
      rxSync2_reg <= rxSync1_reg;
      rxPrev_reg <= rxSync2_reg;
    end
  end

  assign dataBits = nineRx_reg ? asx_pkg::DATA_BITS_9 : asx_pkg::DATA_BITS_8;
  // three samples around the bit centre, decided on the third
  assign vote = (votes_reg[0] & votes_reg[1]) | (votes_reg[0] & rxSync2_reg) |
                (votes_reg[1] & rxSync2_reg);
  assign decideNow = tick16 && rxCnt_reg == asx_pkg::VOTE_DECIDE;
  assign rxChar.frameErr = !vote;
  assign rxChar.data = nineRx_reg ? rxShift_reg : {1'b0, rxShift_reg[8:1]};
  // while overrun stands, finished characters are discarded
  assign fifoPush = rxState_reg == asx_pkg::RX_STOP && decideNow && !overrun_reg;

  always_ff @(posedge clk_sys) begin
    if (rst || !rxActive) begin
      rxState_reg <= asx_pkg::RX_IDLE;
      rxCnt_reg <= 4'h0;
      votes_reg <= 2'b00;
      rxBits_reg <= 4'h0;
      rxShift_reg <= 9'h000;
    end else begin
      if (tick16) begin
        rxCnt_reg <= rxCnt_reg + 4'h1;
        if (rxCnt_reg == asx_pkg::VOTE_FIRST) begin
          votes_reg[0] <= rxSync2_reg;
        end
        if (rxCnt_reg == asx_pkg::VOTE_SECOND) begin
          votes_reg[1] <= rxSync2_reg;
        end
      end
      unique case (rxState_reg)
        asx_pkg::RX_IDLE: begin
          if (rxPrev_reg && !rxSync2_reg) begin
            rxState_reg <= asx_pkg::RX_START;
            rxCnt_reg <= 4'h0;
          end
        end
        asx_pkg::RX_START: begin
          if (decideNow) begin
            rxBits_reg <= 4'h0;
            rxState_reg <= vote ? asx_pkg::RX_IDLE : asx_pkg::RX_DATA;
          end
        end
        asx_pkg::RX_DATA: begin
          if (decideNow) begin
            rxShift_reg <= {vote, rxShift_reg[8:1]};
            rxBits_reg <= rxBits_reg + 4'h1;
            if (rxBits_reg + 4'h1 == dataBits) begin
              rxState_reg <= asx_pkg::RX_STOP;
            end
          end
        end
        asx_pkg::RX_STOP: begin
          if (decideNow) begin
            rxState_reg <= asx_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // the clear is tested first, so it wins over a set that falls in the cycle receive turns off
  always_ff @(posedge clk_sys) begin
    if (rst || !contRx_reg || !portOn_reg) begin
      overrun_reg <= 1'b0;
    end else if (rxState_reg == asx_pkg::RX_STOP && decideNow && fifoFull) begin
      overrun_reg <= 1'b1;
    end
  end

  asx_rx_fifo #(
    .DEPTH(2)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(!portOn_reg),
    .push(fifoPush && !fifoFull),
    .pushData(rxChar),
    .pop(rdRxData),
    .head(fifoHead),
    .empty(fifoEmpty),
    .full(fifoFull)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence sAbortStart;
    rxState_reg == asx_pkg::RX_START && decideNow && vote;
  endsequence
  sequence sBackToIdle;
    rxState_reg == asx_pkg::RX_IDLE && !fifoPush;
  endsequence

  a_start_abort: assert property (sAbortStart |=> sBackToIdle)
    else $error("false start bit not dropped");
  a_tx_flag_set: assert property (wrTxCtrl && busReq.wrData[asx_pkg::TX_ON_BIT] &&
      portOn_reg && txShiftEmpty && txHoldEmpty |=> txFlag)
    else $error("enabling transmitter did not set flag");
  a_irq_raise: assert property (txFlag && txIrqAllow_reg && globalIrq_reg && periphIrq_reg
      |=> irq)
    else $error("transmit interrupt not raised");
  a_rx_gating: assert property (!rxActive |=> rxState_reg == asx_pkg::RX_IDLE)
    else $error("receiver ran while disabled");
  a_push_flag: assert property (fifoPush && !fifoFull |=> rxFlag ##0 !fifoEmpty)
    else $error("push did not set data flag");
  a_pop_read: assert property (rdRxData && !fifoEmpty |=>
      rdData == $past(fifoHead.data[7:0]))
    else $error("read did not return oldest character");
  a_overrun_block: assert property (overrun_reg && fifoEmpty |=> fifoEmpty)
    else $error("character accepted during overrun");
  a_overrun_clear: assert property (!contRx_reg |=> !overrun_reg)
    else $error("overrun not cleared by receive off");
  a_pin_drive: assert property (portOn_reg |=> txLineOe ##1 txLineOe || !portOn_reg)
    else $error("transmit pin not driven with port on");
  a_tx_start: assert property (wrTxBuf && txOn_reg && portOn_reg && !syncMode_reg &&
      txShiftEmpty && txHoldEmpty |=> ##1 !txShiftEmpty)
    else $error("buffer write did not start a character");
endmodule : asx_top
`default_nettype wire

// >>> verilog/asx_pkg.sv
// constants and carrier types for the asynchronous serial port
// assumes one system clock and an external 16x baud tick
package asx_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] ADDR_TX_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RX_CTRL = 3'h1;
  localparam logic [2:0] ADDR_TX_BUF = 3'h2;
  localparam logic [2:0] ADDR_RX_DATA = 3'h3;
  localparam logic [2:0] ADDR_BAUD_POL = 3'h4;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h5;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h6;
  localparam logic [2:0] ADDR_IRQ_CTRL = 3'h7;

  // ****************************************
  // field positions
  // ****************************************
  // transmit_status_control
  localparam int TX_NINE_BIT = 6;
  localparam int TX_ON_BIT = 5;
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HIGH_RATE_BIT = 2;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  localparam int TX_NINTH_DATA_BIT = 0;
  // receive_status_control
  localparam int RX_PORT_ON_BIT = 7;
  localparam int RX_NINE_BIT = 6;
  localparam int RX_CONT_ON_BIT = 4;
  localparam int RX_FRAME_ERR_BIT = 2;
  localparam int RX_OVERRUN_BIT = 1;
  localparam int RX_NINTH_DATA_BIT = 0;
  // baud_and_polarity_control
  localparam int BP_TX_INVERT_BIT = 4;
  localparam int BP_WIDE_DIV_BIT = 3;
  // interrupt control and flags
  localparam int IRQ_GLOBAL_BIT = 7;
  localparam int IRQ_PERIPH_BIT = 6;
  localparam int IRQ_RX_ALLOW_BIT = 5;
  localparam int IRQ_TX_ALLOW_BIT = 4;
  localparam int IRQ_RX_FLAG_BIT = 1;
  localparam int IRQ_TX_FLAG_BIT = 0;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] VOTE_FIRST = 4'h7;
  localparam logic [3:0] VOTE_SECOND = 4'h8;
  localparam logic [3:0] VOTE_DECIDE = 4'h9;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } asx_bus_req_type;

  typedef struct packed {
    logic frameErr;
    logic [8:0] data;
  } asx_rx_char_type;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asx_rx_state_type;

endpackage : asx_pkg

// >>> verilog/asx_tx.sv
// transmit holding buffer and shift register
// assumes a 16x baud tick pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module asx_tx (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic tick16,
  input wire logic nineBits,
  input wire logic load,
  input wire logic [8:0] loadData,
  output logic serialOut,
  output logic holdEmpty,
  output logic shiftEmpty
);
  logic [8:0] hold_reg;
  logic holdFull_reg;
  logic [10:0] frame_reg;
  logic [3:0] bitsLeft_reg;
  logic [3:0] subCnt_reg;
  logic busy;
  logic bitEnd;

  assign busy = (bitsLeft_reg != 4'h0);
  assign bitEnd = busy && tick16 && (subCnt_reg == asx_pkg::OVERSAMPLE_LAST);
  assign serialOut = busy ? frame_reg[0] : 1'b1;
  assign holdEmpty = !holdFull_reg;
  assign shiftEmpty = !busy;

  // ****************************************
  // holding buffer
  // ****************************************
  // all nine bits are captured in one write
  always_ff @(posedge clk_sys) begin
    if (rst || !enable) begin
      holdFull_reg <= 1'b0;
      hold_reg <= 9'h000;
    end else if (load) begin
      holdFull_reg <= 1'b1;
      hold_reg <= loadData;
    end else if (!busy) begin
      holdFull_reg <= 1'b0;
    end
  end

  // ****************************************
  // shifter
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst || !enable) begin
      frame_reg <= 11'h7FF;
      bitsLeft_reg <= 4'h0;
      subCnt_reg <= 4'h0;
    end else if (!busy && holdFull_reg) begin
      // start low, data lsb first, stop high
      frame_reg <= nineBits ? {1'b1, hold_reg, 1'b0} : {2'b11, hold_reg[7:0], 1'b0};
      bitsLeft_reg <= nineBits ? asx_pkg::FRAME_BITS_9 : asx_pkg::FRAME_BITS_8;
      subCnt_reg <= 4'h0;
    end else if (busy && tick16) begin
      subCnt_reg <= subCnt_reg + 4'h1;
      if (bitEnd) begin
        frame_reg <= {1'b1, frame_reg[10:1]};
        bitsLeft_reg <= bitsLeft_reg - 4'h1;
      end
    end
  end
endmodule : asx_tx
`default_nettype wire

// >>> verilog/asx_rx_fifo.sv
// two-entry receive buffer, flip-flop storage
// assumes the caller never pushes while full
`timescale 1ns/1ps
`default_nettype none
module asx_rx_fifo #(
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire asx_pkg::asx_rx_char_type pushData,
  input wire logic pop,
  output asx_pkg::asx_rx_char_type head,
  output logic empty,
  output logic full
);
  asx_pkg::asx_rx_char_type mem_reg [DEPTH];
  logic [$clog2(DEPTH):0] count_reg;
  logic [$clog2(DEPTH)-1:0] rdPtr_reg;
  logic [$clog2(DEPTH)-1:0] wrPtr_reg;
  logic doPush;
  logic doPop;

  assign empty = (count_reg == '0);
  assign full = (count_reg == ($clog2(DEPTH)+1)'(DEPTH));
  assign doPush = push && !full;
  assign doPop = pop && !empty;
  assign head = mem_reg[rdPtr_reg];

  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      count_reg <= '0;
      rdPtr_reg <= '0;
      wrPtr_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= ($clog2(DEPTH))'((wrPtr_reg + 1'b1) % DEPTH);
      end
      if (doPop) begin
        rdPtr_reg <= ($clog2(DEPTH))'((rdPtr_reg + 1'b1) % DEPTH);
      end
      count_reg <= count_reg + {{$clog2(DEPTH){1'b0}}, doPush} - {{$clog2(DEPTH){1'b0}}, doPop};
    end
  end

  // ****************************************
  // storage
  // ****************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        mem_reg[i] <= '0;
      end else if (doPush && wrPtr_reg == i) begin
        mem_reg[i] <= pushData;
      end
    end
  end
endmodule : asx_rx_fifo
`default_nettype wire

// >>> verif/asx_remote.sv
// remote serial partner: sends characters on the receive line, decodes the transmit line
// assumes the bench's 16x tick on the same clock and an idle-high line
`timescale 1ns/1ps
`default_nettype none
module asx_remote (
  input wire logic clk_sys,
  input wire logic tick16,
  input wire logic txLine,
  output logic rxLine
);
  initial rxLine = 1'b1;

  task automatic bitWait(input int n);
    repeat (n) @(posedge clk_sys iff tick16);
  endtask : bitWait

  // stop level is the caller's so a framing fault can be commanded
  task automatic sendChar(input logic [8:0] d, input int n, input logic stopLvl);
    rxLine <= 1'b0;
    bitWait(16);
    for (int i = 0; i < n; i++) begin
      rxLine <= d[i];
      bitWait(16);
    end
    rxLine <= stopLvl;
    bitWait(16);
    rxLine <= 1'b1;
    // idle tick so back-to-back calls never drive the line twice at once
    bitWait(1);
  endtask : sendChar

  // low pulse shorter than half a bit
  task automatic glitch();
    rxLine <= 1'b0;
    bitWait(4);
    rxLine <= 1'b1;
    bitWait(20);
  endtask : glitch

  // returns data bits with the stop level above them
  task automatic getChar(output logic [9:0] d, input int n);
    d = '0;
    @(negedge txLine);
    bitWait(8);
    for (int i = 0; i < n; i++) begin
      bitWait(16);
      d[i] = txLine;
    end
    bitWait(16);
    d[n] = txLine;
  endtask : getChar
endmodule : asx_remote
`default_nettype wire

// >>> verif/asx_top_tb.sv
// self-checking bench for the serial port: registers, transmit, receive, overrun
// assumes asx_remote on the pins and a 16x tick made here every 4 clocks
`timescale 1ns/1ps
`default_nettype none
module asx_top_tb;
  logic clk_sys, rst, tick16, rxLine, txLineOut, txLineOe, irq, highRateSel, wideDivisorSel;
  asx_pkg::asx_bus_req_type busReq;
  logic [7:0] rdData, v;
  logic [15:0] baudDivisor;
  logic [1:0] tickCnt;
  logic [9:0] got;
  logic [8:0] d [4];
  int fail_count, samples_checked, cycles;

  asx_top dut_u (.clk_sys(clk_sys), .rst(rst), .busReq(busReq), .rdData(rdData),
    .tick16(tick16), .rxLine(rxLine), .txLineOut(txLineOut), .txLineOe(txLineOe), .irq(irq),
    .baudDivisor(baudDivisor), .highRateSel(highRateSel), .wideDivisorSel(wideDivisorSel));
  asx_remote rem_u (.clk_sys(clk_sys), .tick16(tick16), .txLine(txLineOut), .rxLine(rxLine));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // short bit time keeps the run small; the ceiling is several times the longest path
  always @(posedge clk_sys) begin
    tickCnt <= rst ? 2'h0 : tickCnt + 2'h1;
    tick16 <= (tickCnt == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  task automatic bus(input logic [2:0] a, input logic [7:0] w, input logic wr,
                     output logic [7:0] r);
    @(posedge clk_sys);
    busReq <= '{addr: a, wrData: w, wrStrobe: wr, rdStrobe: !wr};
    @(posedge clk_sys);
    busReq <= '0;
    #1 r = rdData;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    logic [7:0] r;
    bus(a, w, 1'b1, r);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    bus(a, 8'h00, 1'b0, r);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic getRx(output logic [9:0] g);
    logic [7:0] s, b;
    rd(asx_pkg::ADDR_RX_CTRL, s);
    rd(asx_pkg::ADDR_RX_DATA, b);
    g = {s[asx_pkg::RX_FRAME_ERR_BIT], s[asx_pkg::RX_NINTH_DATA_BIT], b};
  endtask : getRx

  task automatic rxFlag(input logic e, input string m);
    rd(asx_pkg::ADDR_IRQ_CTRL, v);
    chk(16'(v[asx_pkg::IRQ_RX_FLAG_BIT]), 16'(e), m);
  endtask : rxFlag

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    busReq = '0;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(76588));
    for (int i = 0; i < 4; i++)
      d[i] = 9'($urandom_range(511, 0));
    d[0] = 9'h1A5;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    wr(asx_pkg::ADDR_DIV_HIGH, 8'(d[2]));
    wr(asx_pkg::ADDR_DIV_LOW, 8'(d[3]));
    chk(baudDivisor, {8'(d[2]), 8'(d[3])}, "divisor");
    wr(asx_pkg::ADDR_RX_CTRL, 8'hD0);
    settle();
    chk(16'(txLineOe), 16'h0001, "pin enable");
    wr(asx_pkg::ADDR_BAUD_POL, 8'h18);
    settle();
    chk(16'(txLineOut), 16'h0000, "inverted idle");
    chk(16'(wideDivisorSel), 16'h0001, "wide divisor");
    wr(asx_pkg::ADDR_BAUD_POL, 8'h00);
    wr(asx_pkg::ADDR_TX_CTRL, 8'h64);
    chk(16'(highRateSel), 16'h0001, "high rate");
    rd(asx_pkg::ADDR_IRQ_CTRL, v);
    chk(16'(v[asx_pkg::IRQ_TX_FLAG_BIT]), 16'h0001, "tx flag");
    wr(asx_pkg::ADDR_IRQ_CTRL, 8'hD0);
    settle();
    chk(16'(irq), 16'h0001, "tx irq");
    wr(asx_pkg::ADDR_IRQ_CTRL, 8'hE0);
    for (int i = 0; i < 3; i++) begin
      fork
        rem_u.getChar(got, 9);
        begin
          wr(asx_pkg::ADDR_TX_CTRL, {7'h30, d[i][8]});
          wr(asx_pkg::ADDR_TX_BUF, d[i][7:0]);
        end
      join
      chk(16'(got), 16'({1'b1, d[i]}), "tx char");
    end
    rem_u.glitch();
    rxFlag(1'b0, "false start");
    rem_u.sendChar(d[0], 9, 1'b0);
    settle();
    chk(16'(irq), 16'h0001, "rx irq");
    getRx(got);
    chk(16'(got), 16'({1'b1, d[0]}), "framing char");
    for (int i = 0; i < 3; i++)
      rem_u.sendChar(d[i], 9, 1'b1);
    rd(asx_pkg::ADDR_RX_CTRL, v);
    chk(16'(v[asx_pkg::RX_OVERRUN_BIT]), 16'h0001, "overrun set");
    for (int i = 0; i < 2; i++) begin
      getRx(got);
      chk(16'(got), 16'({1'b0, d[i]}), "fifo order");
    end
    rem_u.sendChar(d[3], 9, 1'b1);
    rxFlag(1'b0, "blocked");
    wr(asx_pkg::ADDR_RX_CTRL, 8'hC0);
    rd(asx_pkg::ADDR_RX_CTRL, v);
    chk(16'(v[asx_pkg::RX_OVERRUN_BIT]), 16'h0000, "overrun clear");
    rem_u.sendChar(d[3], 9, 1'b1);
    rxFlag(1'b0, "receive off");
    wr(asx_pkg::ADDR_RX_CTRL, 8'hD0);
    rem_u.sendChar(d[3], 9, 1'b1);
    getRx(got);
    chk(16'(got), 16'({1'b0, d[3]}), "resume");
    // eight-bit characters in both directions
    wr(asx_pkg::ADDR_RX_CTRL, 8'h90);
    fork
      rem_u.getChar(got, 8);
      begin
        wr(asx_pkg::ADDR_TX_CTRL, 8'h20);
        wr(asx_pkg::ADDR_TX_BUF, d[1][7:0]);
      end
    join
    chk(16'(got), 16'({2'b01, d[1][7:0]}), "tx 8-bit");
    rem_u.sendChar(d[2], 8, 1'b1);
    getRx(got);
    chk(16'(got), 16'({2'b00, d[2][7:0]}), "rx 8-bit");
    tally_and_finish();
  end
endmodule : asx_top_tb
`default_nettype wire
